// ### rtl/i2c_mstr_pkg.sv
// Purpose: shared constants of the i2c master engine (register map, fields, reset values)
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   flag register bits are cleared by writing one
package i2c_mstr_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PORT_CONTROL_TWO = 8'h00;
  localparam logic [7:0] OFS_PORT_STATUS      = 8'h04;
  localparam logic [7:0] OFS_BIT_RATE_RELOAD  = 8'h08;
  localparam logic [7:0] OFS_SHIFT_BUFFER     = 8'h0c;
  localparam logic [7:0] OFS_EVENT_FLAGS      = 8'h10;

  // ----------------------------------------------------------------
  // port_control_two fields
  // ----------------------------------------------------------------
  localparam int CT_START      = 0;
  localparam int CT_RESTART    = 1;
  localparam int CT_STOP       = 2;
  localparam int CT_RECV_EN    = 3;
  localparam int CT_ACK_SEQ_EN = 4;
  localparam int CT_ACK_DATA   = 5;
  localparam int CT_ACK_STATUS = 6;
  localparam int CT_REQ_BITS   = 5;

  // ----------------------------------------------------------------
  // port_status fields
  // ----------------------------------------------------------------
  localparam int ST_BUF_FULL  = 0;
  localparam int ST_START_DET = 3;

  // ----------------------------------------------------------------
  // event flag fields
  // ----------------------------------------------------------------
  localparam int FL_IRQ       = 0;
  localparam int FL_WRITE_COL = 1;
  localparam int FL_OVERFLOW  = 2;
  localparam int FL_BUS_COL   = 3;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RATE     = 8'h04;
  localparam logic [3:0] LAST_TX_BIT  = 4'h7;
  localparam logic [3:0] ACK_BIT      = 4'h8;
  localparam logic [3:0] LAST_RX_BIT  = 4'h7;

  typedef enum logic [3:0] {
    ENG_IDLE,
    RS_SCL_LOW,
    RS_SDA_HIGH,
    RS_SCL_REL,
    RS_BOTH_HIGH,
    RS_SDA_LOW,
    TX_LOW,
    TX_REL,
    TX_HIGH,
    RX_LOW,
    RX_REL,
    RX_HIGH
  } eng_state_t;

endpackage

// ### rtl/i2c_master_restart_tx_rx.sv
// Purpose: i2c master engine: repeated start, byte transmit with ack capture, byte receive
// Assumes: scl and sda are open-drain; bus levels arrive asynchronously and are synchronised
// Notes:   registers reached over apb; answer one cycle after the access phase starts
module i2c_master_restart_tx_rx (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  i2c_mstr_pkg::eng_state_t state_r;
  logic [1:0]  scl_sync_r, sda_sync_r;
  logic        scl_s, sda_s, scl_prev_r, sda_prev_r;
  logic [6:0]  cnt_r;
  logic        tick;
  logic [3:0]  bitn_r;
  logic [7:0]  shreg_r, rate_r, buf_r;
  logic        scl_low_r, sda_low_r, tx_go_r, rx_mode_r, buf_full_r, start_det_r;
  logic        restart_r, recv_en_r, start_req_r, stop_req_r, ack_seq_r, ack_data_r;
  logic        ack_status_r, irq_r, write_collision_r, ovf_r, bcol_r, ack_val_r;
  logic        ev_irq_r, ev_bcol_r, ev_bfclr_r, ev_ack_r, ev_rsend_r, ev_rxdone_r;
  logic        pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic        busy, acc, wr_done, rd_done, hit;

  assign scl_s   = scl_sync_r[1];
  assign sda_s   = sda_sync_r[1];
  assign tick    = (cnt_r == 7'h00);
  assign busy    = (state_r != i2c_mstr_pkg::ENG_IDLE) | tx_go_r | restart_r | recv_en_r;
  assign acc     = psel & penable;
  assign wr_done = acc & pready_r & pwrite;
  assign rd_done = acc & pready_r & ~pwrite;
  assign hit     = (paddr == i2c_mstr_pkg::OFS_PORT_CONTROL_TWO) |
                   (paddr == i2c_mstr_pkg::OFS_PORT_STATUS) |
                   (paddr == i2c_mstr_pkg::OFS_BIT_RATE_RELOAD) |
                   (paddr == i2c_mstr_pkg::OFS_SHIFT_BUFFER) |
                   (paddr == i2c_mstr_pkg::OFS_EVENT_FLAGS);

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign scl_oe  = scl_low_r;
  assign sda_oe  = sda_low_r;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
      scl_o      <= 1'b0;
      sda_o      <= 1'b0;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_prev_r <= scl_s;
      sda_prev_r <= sda_s;
    end
  end

  // ----------------------------------------------------------------
  // start detector: sda falls while scl high
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      start_det_r <= 1'b0;
    end else if (scl_s && scl_prev_r && sda_prev_r && !sda_s) begin
      start_det_r <= 1'b1;
    end else if (scl_s && scl_prev_r && !sda_prev_r && sda_s) begin
      start_det_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // one wait state keeps pready and prdata straight from flops
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~hit;
      prdata_r  <= 32'h0000_0000;
      if (acc && !pready_r && !pwrite) begin
        unique case (paddr)
          i2c_mstr_pkg::OFS_PORT_CONTROL_TWO:
            prdata_r[6:0] <= {ack_status_r, ack_data_r, ack_seq_r, recv_en_r,
                              stop_req_r, restart_r, start_req_r};
          i2c_mstr_pkg::OFS_PORT_STATUS: begin
            prdata_r[i2c_mstr_pkg::ST_BUF_FULL]  <= buf_full_r;
            prdata_r[i2c_mstr_pkg::ST_START_DET] <= start_det_r;
          end
          i2c_mstr_pkg::OFS_BIT_RATE_RELOAD: prdata_r[7:0] <= rate_r;
          i2c_mstr_pkg::OFS_SHIFT_BUFFER:    prdata_r[7:0] <= buf_r;
          i2c_mstr_pkg::OFS_EVENT_FLAGS:
            prdata_r[3:0] <= {bcol_r, ovf_r, write_collision_r, irq_r};
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      restart_r    <= 1'b0;
      recv_en_r    <= 1'b0;
      start_req_r  <= 1'b0;
      stop_req_r   <= 1'b0;
      ack_seq_r    <= 1'b0;
      ack_data_r   <= 1'b0;
      ack_status_r <= 1'b0;
      rate_r       <= i2c_mstr_pkg::RST_RATE;
    end else begin
      if (wr_done && paddr == i2c_mstr_pkg::OFS_PORT_CONTROL_TWO) begin
        ack_data_r <= pwdata[i2c_mstr_pkg::CT_ACK_DATA];
        if (!busy) begin
          start_req_r <= pwdata[i2c_mstr_pkg::CT_START];
          restart_r   <= pwdata[i2c_mstr_pkg::CT_RESTART];
          stop_req_r  <= pwdata[i2c_mstr_pkg::CT_STOP];
          recv_en_r   <= pwdata[i2c_mstr_pkg::CT_RECV_EN];
          ack_seq_r   <= pwdata[i2c_mstr_pkg::CT_ACK_SEQ_EN];
        end
      end
      if (wr_done && paddr == i2c_mstr_pkg::OFS_BIT_RATE_RELOAD) rate_r <= pwdata[7:0];
      if (ev_rsend_r || ev_bcol_r) restart_r <= 1'b0;
      if (ev_rxdone_r) recv_en_r <= 1'b0;
      if (ev_ack_r) ack_status_r <= ack_val_r;
    end
  end

  // ----------------------------------------------------------------
  // shift buffer and buffer-full
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      buf_r      <= 8'h00;
      buf_full_r <= 1'b0;
      tx_go_r    <= 1'b0;
      rx_mode_r  <= 1'b0;
    end else begin
      if (state_r != i2c_mstr_pkg::ENG_IDLE) begin
        tx_go_r <= 1'b0;
      end
      if (wr_done && paddr == i2c_mstr_pkg::OFS_SHIFT_BUFFER && !busy) begin
        buf_r      <= pwdata[7:0];
        buf_full_r <= 1'b1;
        tx_go_r    <= 1'b1;
        rx_mode_r  <= 1'b0;
      end
      if (rd_done && paddr == i2c_mstr_pkg::OFS_SHIFT_BUFFER && rx_mode_r) begin
        buf_full_r <= 1'b0;
      end
      if (ev_bfclr_r) begin
        buf_full_r <= 1'b0;
      end
      if (ev_rxdone_r) begin
        buf_r      <= shreg_r;
        buf_full_r <= 1'b1;
        rx_mode_r  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // event flags, write one to clear, a set wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_r  <= 1'b0;
      write_collision_r <= 1'b0;
      ovf_r  <= 1'b0;
      bcol_r <= 1'b0;
    end else begin
      if (wr_done && paddr == i2c_mstr_pkg::OFS_EVENT_FLAGS) begin
        if (pwdata[i2c_mstr_pkg::FL_IRQ])       irq_r  <= 1'b0;
        if (pwdata[i2c_mstr_pkg::FL_WRITE_COL]) write_collision_r <= 1'b0;
        if (pwdata[i2c_mstr_pkg::FL_OVERFLOW])  ovf_r  <= 1'b0;
        if (pwdata[i2c_mstr_pkg::FL_BUS_COL])   bcol_r <= 1'b0;
      end
      if (ev_irq_r) irq_r <= 1'b1;
      if (wr_done && paddr == i2c_mstr_pkg::OFS_SHIFT_BUFFER && busy) begin
        write_collision_r <= 1'b1;
      end
      if (ev_rxdone_r && buf_full_r) ovf_r <= 1'b1;
      if (ev_bcol_r) bcol_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // engine: rate counter, line drivers, bit sequencing
  // ----------------------------------------------------------------
  // waits on scl high after release so a slave may stretch the clock
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r     <= i2c_mstr_pkg::ENG_IDLE;
      cnt_r       <= 7'h00;
      bitn_r      <= 4'h0;
      shreg_r     <= 8'h00;
      scl_low_r   <= 1'b0;
      sda_low_r   <= 1'b0;
      ev_irq_r    <= 1'b0;
      ev_bcol_r   <= 1'b0;
      ev_bfclr_r  <= 1'b0;
      ev_ack_r    <= 1'b0;
      ack_val_r   <= 1'b0;
      ev_rsend_r  <= 1'b0;
      ev_rxdone_r <= 1'b0;
    end else begin
      ev_irq_r    <= 1'b0;
      ev_bcol_r   <= 1'b0;
      ev_bfclr_r  <= 1'b0;
      ev_ack_r    <= 1'b0;
      ev_rsend_r  <= 1'b0;
      ev_rxdone_r <= 1'b0;
      if (!tick) begin
        cnt_r <= cnt_r - 7'h01;
      end
      unique case (state_r)
        // request bits drop a cycle late: the finishing event must not relaunch them
        i2c_mstr_pkg::ENG_IDLE: begin
          if (restart_r && !ev_rsend_r && !ev_bcol_r) begin
            scl_low_r <= 1'b1;
            state_r   <= i2c_mstr_pkg::RS_SCL_LOW;
          end else if (recv_en_r && !ev_rxdone_r) begin
            scl_low_r <= 1'b1;
            cnt_r     <= rate_r[6:0];
            bitn_r    <= 4'h0;
            state_r   <= i2c_mstr_pkg::RX_LOW;
          end else if (tx_go_r) begin
            scl_low_r <= 1'b1;
            shreg_r   <= buf_r;
            cnt_r     <= rate_r[6:0];
            bitn_r    <= 4'h0;
            state_r   <= i2c_mstr_pkg::TX_LOW;
          end
        end
        i2c_mstr_pkg::RS_SCL_LOW: begin
          if (!scl_s) begin
            cnt_r     <= {1'b0, rate_r[5:0]};
            sda_low_r <= 1'b0;
            state_r   <= i2c_mstr_pkg::RS_SDA_HIGH;
          end
        end
        i2c_mstr_pkg::RS_SDA_HIGH: begin
          if (tick && sda_s) begin
            scl_low_r <= 1'b0;
            state_r   <= i2c_mstr_pkg::RS_SCL_REL;
          end else if (tick) begin
            ev_bcol_r <= 1'b1;
            scl_low_r <= 1'b0;
            state_r   <= i2c_mstr_pkg::ENG_IDLE;
          end
        end
        i2c_mstr_pkg::RS_SCL_REL: begin
          if (scl_s && !sda_s) begin
            ev_bcol_r <= 1'b1;
            state_r   <= i2c_mstr_pkg::ENG_IDLE;
          end else if (scl_s) begin
            cnt_r   <= rate_r[6:0];
            state_r <= i2c_mstr_pkg::RS_BOTH_HIGH;
          end
        end
        i2c_mstr_pkg::RS_BOTH_HIGH: begin
          if (!scl_s) begin
            ev_bcol_r <= 1'b1;
            state_r   <= i2c_mstr_pkg::ENG_IDLE;
          end else if (tick) begin
            sda_low_r <= 1'b1;
            cnt_r     <= rate_r[6:0];
            state_r   <= i2c_mstr_pkg::RS_SDA_LOW;
          end
        end
        i2c_mstr_pkg::RS_SDA_LOW: begin
          if (tick) begin
            ev_rsend_r <= 1'b1;
            ev_irq_r   <= 1'b1;
            state_r    <= i2c_mstr_pkg::ENG_IDLE;
          end
        end
        i2c_mstr_pkg::TX_LOW: begin
          // data moves a cycle after scl is driven low, never with the edge
          sda_low_r <= (bitn_r == i2c_mstr_pkg::ACK_BIT) ? 1'b0 : ~shreg_r[7];
          if (tick) begin
            scl_low_r <= 1'b0;
            state_r   <= i2c_mstr_pkg::TX_REL;
          end
        end
        i2c_mstr_pkg::TX_REL: begin
          if (scl_s) begin
            cnt_r   <= rate_r[6:0];
            state_r <= i2c_mstr_pkg::TX_HIGH;
          end
        end
        i2c_mstr_pkg::TX_HIGH: begin
          if (tick) begin
            scl_low_r <= 1'b1;
            cnt_r     <= rate_r[6:0];
            if (bitn_r == i2c_mstr_pkg::ACK_BIT) begin
              ev_ack_r  <= 1'b1;
              ack_val_r <= sda_s;
              ev_irq_r  <= 1'b1;
              state_r   <= i2c_mstr_pkg::ENG_IDLE;
            end else if (bitn_r == i2c_mstr_pkg::LAST_TX_BIT) begin
              ev_bfclr_r <= 1'b1;
              bitn_r     <= i2c_mstr_pkg::ACK_BIT;
              state_r    <= i2c_mstr_pkg::TX_LOW;
            end else begin
              shreg_r   <= {shreg_r[6:0], 1'b0};
              bitn_r    <= bitn_r + 4'h1;
              state_r   <= i2c_mstr_pkg::TX_LOW;
            end
          end
        end
        i2c_mstr_pkg::RX_LOW: begin
          sda_low_r <= 1'b0;
          if (tick) begin
            scl_low_r <= 1'b0;
            state_r   <= i2c_mstr_pkg::RX_REL;
          end
        end
        i2c_mstr_pkg::RX_REL: begin
          if (scl_s) begin
            cnt_r   <= rate_r[6:0];
            state_r <= i2c_mstr_pkg::RX_HIGH;
          end
        end
        i2c_mstr_pkg::RX_HIGH: begin
          if (tick) begin
            shreg_r   <= {shreg_r[6:0], sda_s};
            scl_low_r <= 1'b1;
            cnt_r     <= rate_r[6:0];
            if (bitn_r == i2c_mstr_pkg::LAST_RX_BIT) begin
              ev_rxdone_r <= 1'b1;
              ev_irq_r    <= 1'b1;
              state_r     <= i2c_mstr_pkg::ENG_IDLE;
            end else begin
              bitn_r  <= bitn_r + 4'h1;
              state_r <= i2c_mstr_pkg::RX_LOW;
            end
          end
        end
      endcase
    end
  end

endmodule

// ### verification/i2c_master_restart_tx_rx_properties.sv
// Purpose: port-level assertions of the i2c master engine
// Assumes: rate reload whose bits 5:0 hold 3 or more, so every scl or start phase spans at least 4 cycles
// Notes:   bound to every instance of the engine
module i2c_mstr_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  property p_ready_wait;
    psel && $rose(penable) |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not in second access cycle");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_err_map;
    pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h10);
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr does not match address map");

  // ----------------------------------------------------------------
  // bus lines
  // ----------------------------------------------------------------
  property p_open_drain;
    !scl_o && !sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_restart_go;
    psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[1] |-> ##[1:3] scl_oe;
  endproperty
  a_restart_go: assert property (p_restart_go) else $error("restart did not pull scl");
  property p_start_hold;
    $rose(sda_oe) && !scl_oe |-> sda_oe [*4];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start low too short");
  // data may only move while scl is held low, the start being the one exception
  property p_sda_rel;
    $fell(sda_oe) |-> scl_oe;
  endproperty
  a_sda_rel: assert property (p_sda_rel) else $error("sda released with scl high");
  property p_low_hold;
    $rose(scl_oe) |-> scl_oe [*4];
  endproperty
  a_low_hold: assert property (p_low_hold) else $error("scl low too short");
  property p_high_hold;
    $fell(scl_oe) |-> !scl_oe [*4];
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("scl high too short");

  property p_rdata_idle;
    !pready |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero outside answer");
  property p_data_setup;
    $changed(sda_oe) && scl_oe |-> $past(scl_oe);
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("sda moved with scl fall");

  c_start: cover property ($rose(sda_oe) && !scl_oe);
  c_unmapped: cover property (pslverr);
  c_ack_low: cover property ($fell(scl_oe) && !sda_oe && !sda_i);
endmodule

bind i2c_master_restart_tx_rx i2c_mstr_checker u_chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe)
);

// ### verification/i2c_slave_model.sv
// Purpose: behavioural slave on the open-drain bus (ack, read data, stretch, sda jam)
// Assumes: bits counted on scl rises, data moved on scl falls only
// Notes:   a start on the wire resets the bit count
module i2c_slave_model (
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       rd,
  input wire logic       ack_en,
  input wire logic       hold,
  input wire logic       slow,
  input wire logic [7:0] rbyte,
  output logic           scl_pull,
  output logic           sda_pull,
  output logic [7:0]     got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  logic [3:0] pos = 4'h0;
  logic [7:0] cap = 8'h00;
  initial begin
    scl_pull = 1'b0;
    got = 8'h00;
  end
  always @(posedge scl) begin
    cap = {cap[6:0], sda};
    if (cnt == 4'h7) got = cap;
    cnt = cnt + 4'h1;
  end
  // reads carry no ack slot here, so a read byte wraps at 8
  always @(negedge scl) begin
    if (cnt == (rd ? 4'h8 : 4'h9)) cnt = 4'h0;
    pos = cnt;
    if (slow) begin
      scl_pull = 1'b1;
      #600 scl_pull = 1'b0;
    end
  end
  always @(negedge sda) if (scl) begin
    cnt = 4'h0;
    pos = 4'h0;
  end
  assign sda_pull = hold ||
    (rd ? !rbyte[3'h7 - pos[2:0]] : (ack_en && pos == 4'h8));
endmodule

// ### verification/i2c_master_restart_tx_rx_tb.sv
// Purpose: self-checking bench of the i2c master engine
// Assumes: partner slave on open-drain wires with pull-ups
// Notes:   rate 3 gives a 550 ns scl period at 20 MHz
`define CHK(g, x) begin n_compared++; if ((g) !== (x)) begin err_total++; \
  $display("mismatch at %0t: got %0h expected %0h", $time, g, x); end end
module i2c_master_restart_tx_rx_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] a_ctrl = i2c_mstr_pkg::OFS_PORT_CONTROL_TWO;
  localparam logic [7:0] a_stat = i2c_mstr_pkg::OFS_PORT_STATUS;
  localparam logic [7:0] a_buf  = i2c_mstr_pkg::OFS_SHIFT_BUFFER;
  localparam logic [7:0] a_flag = i2c_mstr_pkg::OFS_EVENT_FLAGS;
  logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, s_byte = 8'h00, s_got, b;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, e;
  logic        s_rd = 1'b0, s_ack = 1'b1, s_hold = 1'b0, s_slow = 1'b0;
  wire logic   scl_pull, sda_pull;
  wire logic   scl = !(scl_oe || scl_pull);
  wire logic   sda = !(sda_oe || sda_pull);
  int          err_total = 0, n_compared = 0;

  always #25 clk = ~clk;

  i2c_master_restart_tx_rx i_dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe));
  i2c_slave_model i_slave (
    .scl(scl), .sda(sda), .rd(s_rd), .ack_en(s_ack), .hold(s_hold), .slow(s_slow),
    .rbyte(s_byte), .scl_pull(scl_pull), .sda_pull(sda_pull), .got(s_got));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
      err_total++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // polling keeps going through the slow engine phases, bounded
  task automatic poll(input logic [7:0] a, input int k, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (q[k] !== v && n < 300);
    `CHK(q[k], v)
  endtask

  task automatic wrap_up();
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #500000;
    err_total++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h5718));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    apb(1'b0, i2c_mstr_pkg::OFS_BIT_RATE_RELOAD, 32'h0);
    `CHK(q[7:0], i2c_mstr_pkg::RST_RATE)
    apb(1'b0, a_flag, 32'h0);
    `CHK(q[3:0], 4'h0)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(e, 1'b1)
    apb(1'b1, i2c_mstr_pkg::OFS_BIT_RATE_RELOAD, 32'h3);
    // restart, with a buffer write and a receive request that must bounce
    apb(1'b1, a_ctrl, 32'h2);
    apb(1'b1, a_buf, 32'h5a);
    apb(1'b1, a_ctrl, 32'h8);
    poll(a_ctrl, i2c_mstr_pkg::CT_RESTART, 1'b0);
    `CHK(sda, 1'b0)
    apb(1'b0, a_ctrl, 32'h0);
    `CHK(q[i2c_mstr_pkg::CT_RECV_EN], 1'b0)
    apb(1'b0, a_stat, 32'h0);
    `CHK(q[i2c_mstr_pkg::ST_START_DET], 1'b1)
    apb(1'b0, a_flag, 32'h0);
    `CHK(q[3:0], 4'h3)
    apb(1'b0, a_buf, 32'h0);
    `CHK(q[7:0], 8'h00)
    apb(1'b1, a_flag, 32'hf);
    // transmit: all ones, all zeros, a refused ack, a stretching slave
    for (int i = 0; i < 4; i++) begin
      b = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      s_ack <= (i != 2);
      s_slow <= (i == 3);
      apb(1'b1, a_buf, {24'h0, b});
      apb(1'b0, a_stat, 32'h0);
      `CHK(q[i2c_mstr_pkg::ST_BUF_FULL], 1'b1)
      apb(1'b1, a_buf, {24'h0, ~b});
      poll(a_flag, i2c_mstr_pkg::FL_IRQ, 1'b1);
      `CHK(s_got, b)
      apb(1'b0, a_buf, 32'h0);
      `CHK(q[7:0], b)
      `CHK(scl, 1'b0)
      apb(1'b0, a_stat, 32'h0);
      `CHK(q[i2c_mstr_pkg::ST_BUF_FULL], 1'b0)
      apb(1'b0, a_ctrl, 32'h0);
      `CHK(q[i2c_mstr_pkg::CT_ACK_STATUS], (i == 2))
      apb(1'b0, a_flag, 32'h0);
      `CHK(q[3:0], 4'h3)
      apb(1'b1, a_flag, 32'hf);
    end
    // receive three bytes; the third lands on an unread buffer
    s_slow <= 1'b0;
    s_rd <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      b = 8'($urandom);
      s_byte <= b;
      apb(1'b1, a_ctrl, 32'h8);
      if (j == 0) apb(1'b1, a_buf, 32'ha5);
      poll(a_ctrl, i2c_mstr_pkg::CT_RECV_EN, 1'b0);
      apb(1'b0, a_stat, 32'h0);
      `CHK(q[i2c_mstr_pkg::ST_BUF_FULL], 1'b1)
      apb(1'b0, a_flag, 32'h0);
      `CHK(q[3:0], (j == 0) ? 4'h3 : (j == 1) ? 4'h1 : 4'h5)
      apb(1'b1, a_flag, 32'hf);
      if (j == 0) begin
        apb(1'b0, a_buf, 32'h0);
        `CHK(q[7:0], b)
        apb(1'b0, a_stat, 32'h0);
        `CHK(q[i2c_mstr_pkg::ST_BUF_FULL], 1'b0)
      end
    end
    // restart against a jammed sda
    s_rd <= 1'b0;
    s_hold <= 1'b1;
    apb(1'b1, a_ctrl, 32'h2);
    poll(a_ctrl, i2c_mstr_pkg::CT_RESTART, 1'b0);
    apb(1'b0, a_flag, 32'h0);
    `CHK(q[i2c_mstr_pkg::FL_BUS_COL], 1'b1)
    `CHK({scl_oe, sda_oe}, 2'b00)
    s_hold <= 1'b0;
    wrap_up();
  end
endmodule
